// [logic/lcv_consts.svh]
// Constants for the line code and violation receiver channel
// Behaviour
// - Mode bit 0 and tuned: violations on isolated or paired marks are counted.
// - Violations inside runs longer than two marks may go uncounted.
// - Violation-mode control bit comes out of reset at 1.
// - Mode 1: same-polarity mark after a mark becomes zero, uncounted.
// - Violation preceded by a space is always detected, and in AMI always counted.
// - Alternating or sparse mark patterns show every violation in either mode.
// - Mode 1 all-marks framed pattern reports violations only after a zero.
// - Substitution patterns never hold back-to-back violations, so no conversion.
// - Tuning is shared and cleared by receive reset; host must repeat it.
// - Dual-rail AMI bypasses the encoder; received rails appear separately.
// - Single-rail coded modes output data and violation; transmit uses encoder.
// - Ternary input unless optical select set and line code field is 01.
// - Line code field picks HDB3 or AMI (E1), B8ZS or AMI (T1).
// - Optical input decodes CMI then HDB3 or AMI; CMI errors pass through.
// - HDB3 uses double-violation or extended detection per select bit.
// - AMI flags each violation not converted or missed; each error bumps a 16-bit counter that holds at ffff.
// - Three-bit source field picks recovered or synthesizer clock and its rate.
// - Each of four clock pins picks any channel clock by its own field.
`ifndef LCV_CONSTS_SVH
`define LCV_CONSTS_SVH
// Timing
`define LCV_CLK_NS         40
`define LCV_BIT_NS         488
// Reset values
`define LCV_MODE_RST       1'b1
// Tuning sequence
`define LCV_TUNE_PTR_FIRST 8'h2c
`define LCV_TUNE_COMMIT    8'h80
`define LCV_TUNE_PTR_END   8'h00
`define LCV_TUNE_ONES      8'hff
`define LCV_TUNE_ZEROS     8'h00
`define LCV_TUNE_ONES_MASK 6'h2d
`define LCV_TUNE_GROUPS    3'd6
`define LCV_TUNE_LAST_PH   2'd2
// Decoder
`define LCV_CV_MAX         16'hffff
`define LCV_ZRUN_MAX       3'h7
`define LCV_HDB3_ZEROS     3'h3
`define LCV_B8_WINDOW      2'h3
`define LCV_HDB3_CLR       8'h07
`define LCV_B8_CLR         8'h03
`define LCV_RUN_LONG       2'h2
// Clocks and buffering
`define LCV_RS_RECOVERED   3'h0
`define LCV_SYNTH_UNIT     8'h06
`define LCV_CHANNELS       4
`define LCV_FIFO_DEPTH     16
`endif

// [logic/lcv_pkg.sv]
// Types shared by the line code and violation receiver
package lcv_pkg;

  typedef enum logic [1:0] {
    CODE_NRZ = 2'b00,
    CODE_CMI = 2'b01,
    CODE_AMI = 2'b10,
    CODE_HDB = 2'b11
  } line_code_e;

  typedef enum logic [1:0] {
    TUNE_IDLE = 2'b00,
    TUNE_RUN  = 2'b01,
    TUNE_DONE = 2'b10
  } tune_state_e;

  // One host write to the global pointer or data register
  typedef struct packed {
    logic       wr_ptr;
    logic       wr_data;
    logic [7:0] value;
  } tune_wr_s;

  // Receive word towards the framer
  typedef struct packed {
    logic first;
    logic second;
  } rx_word_s;

  typedef struct packed {
    logic [2:0]      a_s;
    logic [2:0]      b_s;
    logic [2:0]      o_s;
    logic            a_l;
    logic            b_l;
    logic            o_l;
    logic [3:0][2:0] ck_s;
    logic [3:0]      ck_l;
    logic [7:0]      div;
    logic            half;
    logic            cmi_h1;
    logic            mode;
    logic            have_mark;
    logic            prev_neg;
    logic [1:0]      run;
    logic [2:0]      zrun;
    logic            lastv_neg;
    logic [1:0]      b8_pend;
    logic            skip;
    logic [7:0]      ddly;
    logic [7:0]      vdly;
    logic [15:0]     cv;
    tune_state_e     tst;
    logic [2:0]      grp;
    logic [1:0]      ph;
    logic [7:0]      rdiv;
    logic            rclk;
    logic [3:0]      pins;
    logic            tx_p;
    logic            tx_n;
    logic            tx_lastneg;
    logic            ovf;
  } rx_state_s;

endpackage

// [logic/line_code_violation_rx.sv]
// Receive line decoder, violation counter, clock selection and framer FIFO
`timescale 1ns/1ps
`default_nettype none
`include "lcv_consts.svh"

// =====================================================================
// Shift-style FIFO: head word always sits in flop zero
module lcv_fifo #(
  parameter int Width = 2,
  parameter int Depth = `LCV_FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [Width-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [Width-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int CntW = $clog2(Depth + 1);

  typedef struct packed {
    logic [Depth-1:0][Width-1:0] mem;
    logic [CntW-1:0]             cnt;
    logic                        valid;
    logic                        full;
  } fifo_state_s;

  fifo_state_s q;
  fifo_state_s d;
  logic        push;
  logic        pop;
  logic [CntW-1:0] idx;

  if (Depth < 2 || Width < 1) begin : g_bad
    $error("lcv_fifo: depth must be at least 2");
  end

  // Shift on pop, write behind the last held word
  always_comb begin
    d    = q;
    push = in_valid_in && !q.full;
    pop  = q.valid && out_ready_in;
    idx  = q.cnt;
    if (pop) begin
      for (int i = 0; i < Depth - 1; i++) begin
        d.mem[i] = q.mem[i+1];
      end
      idx = q.cnt - 1'b1;
    end
    if (push) begin
      d.mem[idx] = in_data_in;
    end
    d.cnt   = idx + CntW'(push);
    d.valid = (d.cnt != '0);
    d.full  = (d.cnt == CntW'(Depth));
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_out  = !q.full;
  assign out_valid_out = q.valid;
  assign out_data_out  = q.mem[0];

  a_fifo_no_overrun: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    q.full |=> (q.cnt == CntW'(Depth)) || $past(pop))
    else $error("fifo count changed while full without a pop");
endmodule

// =====================================================================
// One receive channel with its transmit rail mapping
module line_code_violation_rx
  import lcv_pkg::*;
#(
  parameter int Channel   = 0,
  parameter int FifoDepth = `LCV_FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ternary_input_a_in,
  input  wire logic        ternary_input_b_in,
  input  wire logic        optical_rx_input_in,
  input  wire logic [3:0]  other_rx_clocks_in,
  input  wire logic        violation_mode_bit_in,
  input  wire logic        optical_input_sel_in,
  input  wire logic [1:0]  line_code_field_in,
  input  wire logic        dual_rail_sel_in,
  input  wire logic        extended_violation_sel_in,
  input  wire logic        t1_mode_in,
  input  wire logic        cmi_hdb3_post_in,
  input  wire tune_wr_s    global_reg_wr_in,
  input  wire logic        receive_reset_cmd_in,
  input  wire logic [2:0]  rx_clock_source_sel_in,
  input  wire logic [11:0] clock_pin_source_sel_in,
  input  wire logic        tx_positive_input_in,
  input  wire logic        tx_negative_input_in,
  input  wire logic        rx_ready_in,
  output logic             rx_valid_out,
  output logic             rx_first_output_out,
  output logic             rx_second_output_out,
  output logic             rx_overflow_out,
  output logic             tx_line_pos_out,
  output logic             tx_line_neg_out,
  output logic             rx_clock_out,
  output logic [3:0]       clock_pins_out,
  output logic [15:0]      cv_count_out,
  output logic             tuned_out
);
  localparam int BitCyc  = `LCV_BIT_NS / `LCV_CLK_NS;
  localparam int HalfCyc = BitCyc / 2;

  if (HalfCyc < 1 || Channel < 0 || Channel >= `LCV_CHANNELS) begin : g_bad
    $error("line_code_violation_rx: bad channel or bit timing");
  end

  rx_state_s  q;
  rx_state_s  d;
  line_code_e code;
  rx_word_s   word;
  logic       half_tick, bit_tick, use_opt, dual, tuned_on;
  logic       raw_mark, raw_neg, cmi_err, bipolar_violation, conv, miss, mark, vio;
  logic       err, data, sec, fifo_ready;
  logic [7:0] clr, shifted;
  logic [2:0] psel;
  tune_wr_s   expect_wr;

  // A change counts once the second and third stages agree
  function automatic logic settle(input logic [2:0] s, input logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction

  // Expected host write at a point of the tuning sequence
  function automatic tune_wr_s tune_expect(input logic [2:0] grp, input logic [1:0] ph);
    tune_wr_s   w;
    logic [7:0] ptr;
    logic [5:0] ones;
    w    = '0;
    ones = `LCV_TUNE_ONES_MASK;  // A literal cannot be indexed directly
    ptr  = `LCV_TUNE_PTR_FIRST - {5'h00, grp};
    if (grp == `LCV_TUNE_GROUPS) begin
      w.wr_ptr = 1'b1;
      w.value  = `LCV_TUNE_PTR_END;
    end else if (ph == 2'h1) begin
      w.wr_data = 1'b1;
      w.value   = ones[grp] ? `LCV_TUNE_ONES : `LCV_TUNE_ZEROS;
    end else begin
      w.wr_ptr = 1'b1;
      w.value  = (ph == `LCV_TUNE_LAST_PH) ? (ptr | `LCV_TUNE_COMMIT) : ptr;
    end
    return w;
  endfunction

  // =====================================================================
  // Next-state logic
  always_comb begin
    d          = q;
    half_tick  = 1'b0;
    clr        = 8'h00;
    err        = 1'b0;
    psel       = 3'h0;
    expect_wr  = tune_expect(q.grp, q.ph);
    // Line pins come from outside, so three stages each
    d.a_s = {q.a_s[1:0], ternary_input_a_in};
    d.b_s = {q.b_s[1:0], ternary_input_b_in};
    d.o_s = {q.o_s[1:0], optical_rx_input_in};
    d.a_l = settle(q.a_s, q.a_l);
    d.b_l = settle(q.b_s, q.b_l);
    d.o_l = settle(q.o_s, q.o_l);
    for (int i = 0; i < `LCV_CHANNELS; i++) begin
      d.ck_s[i] = {q.ck_s[i][1:0], other_rx_clocks_in[i]};
      d.ck_l[i] = settle(q.ck_s[i], q.ck_l[i]);
    end
    d.mode = violation_mode_bit_in;
    // Half-bit divider; bit boundary every second half
    if (q.div == 8'(HalfCyc - 1)) begin
      d.div     = 8'h00;
      half_tick = 1'b1;
      d.half    = ~q.half;
    end else begin
      d.div = q.div + 8'h01;
    end
    bit_tick = half_tick && q.half;
    dual     = dual_rail_sel_in;
    // Optical only with the CMI field value, else ternary pair
    use_opt = optical_input_sel_in && (line_code_field_in == CODE_CMI);
    if (use_opt) begin
      code = cmi_hdb3_post_in ? CODE_HDB : CODE_AMI;
    end else begin
      code = line_code_e'(line_code_field_in);
    end
    // CMI 1T2B: 01 is a space, 00/11 a mark, 10 is passed on as an error
    if (half_tick && !q.half) begin
      d.cmi_h1 = q.o_l;
    end
    cmi_err  = use_opt && q.cmi_h1 && !q.o_l;
    raw_mark = use_opt ? (q.cmi_h1 == q.o_l) : (q.a_l ^ q.b_l);
    raw_neg  = use_opt ? ~q.o_l : q.b_l;
    bipolar_violation      = raw_mark && q.have_mark && (raw_neg == q.prev_neg);
    tuned_on = !q.mode && (q.tst == TUNE_DONE);
    // Legacy mode turns a second same-polarity mark into a zero
    conv = bipolar_violation && (q.run != 2'h0) && !tuned_on;
    // Tuned detector still loses violations deep inside long mark runs
    miss = bipolar_violation && tuned_on && (q.run >= `LCV_RUN_LONG);
    mark = raw_mark && !conv;
    vio  = bipolar_violation && !conv && !miss;
    data = mark;
    // Substitution patterns never hold back-to-back violations
    unique case (code)
      CODE_NRZ: begin
        data = q.a_l;
      end
      CODE_AMI, CODE_CMI: begin
        err = vio;
      end
      CODE_HDB: begin
        if (t1_mode_in) begin
          if (vio) begin
            data = 1'b0;
            if (q.b8_pend != 2'h0) begin
              clr = `LCV_B8_CLR;
            end else if (q.zrun < `LCV_HDB3_ZEROS) begin
              err = 1'b1;
            end
          end
        end else if (vio) begin
          data = 1'b0;
          clr  = `LCV_HDB3_CLR;
          err  = (raw_neg == q.lastv_neg);
        end else if (extended_violation_sel_in && !mark) begin
          err = (q.zrun == `LCV_HDB3_ZEROS);
        end
      end
    endcase
    err = err || cmi_err;
    if (q.skip) begin
      data = 1'b0;
    end
    // Dual rail hands the undecoded rails to the framer
    if (dual) begin
      clr  = 8'h00;
      data = (code == CODE_NRZ) ? q.a_l : (mark && !raw_neg);
      sec  = (code == CODE_NRZ) ? q.b_l : (mark && raw_neg);
    end else begin
      sec = (code == CODE_NRZ) ? 1'b0 : err;
    end
    shifted = q.ddly & ~clr;
    word.first  = q.ddly[7];
    word.second = q.vdly[7];
    if (bit_tick) begin
      d.ddly = {shifted[6:0], data};
      d.vdly = {q.vdly[6:0], sec};
      d.skip = !dual && t1_mode_in && (code == CODE_HDB) && vio && (q.b8_pend != 2'h0);
      if (err && q.cv != `LCV_CV_MAX) begin
        d.cv = q.cv + 16'h0001;
      end
      if (mark) begin
        d.have_mark = 1'b1;
        d.prev_neg  = raw_neg;
        d.run       = (q.run == 2'h3) ? q.run : q.run + 2'h1;
        d.zrun      = 3'h0;
      end else begin
        d.run  = 2'h0;
        d.zrun = (q.zrun == `LCV_ZRUN_MAX) ? q.zrun : q.zrun + 3'h1;
      end
      if (vio && code == CODE_HDB) begin
        d.lastv_neg = raw_neg;
      end
      if (vio && t1_mode_in && code == CODE_HDB) begin
        d.b8_pend = (q.b8_pend == 2'h0) ? `LCV_B8_WINDOW : 2'h0;
      end else if (q.b8_pend != 2'h0) begin
        d.b8_pend = q.b8_pend - 2'h1;
      end
      // Line cannot stall, so a full FIFO drops the word and flags it
      if (!fifo_ready) begin
        d.ovf = 1'b1;
      end
      // Transmit rails; coded single-rail modes use plain AMI marks only
      if (dual && code == CODE_AMI) begin
        d.tx_p = tx_positive_input_in;
        d.tx_n = tx_negative_input_in;
      end else if (code == CODE_NRZ) begin
        d.tx_p = tx_positive_input_in;
        d.tx_n = tx_negative_input_in;
      end else begin
        d.tx_p = tx_positive_input_in && q.tx_lastneg;
        d.tx_n = tx_positive_input_in && !q.tx_lastneg;
        d.tx_lastneg = q.tx_lastneg ^ tx_positive_input_in;
      end
    end
    // Tuning tracker; any stray write restarts the match
    if (q.tst != TUNE_DONE && (global_reg_wr_in.wr_ptr || global_reg_wr_in.wr_data)) begin
      if (global_reg_wr_in == expect_wr) begin
        d.tst = TUNE_RUN;
        if (q.grp == `LCV_TUNE_GROUPS) begin
          d.tst = TUNE_DONE;
        end else if (q.ph == `LCV_TUNE_LAST_PH) begin
          d.ph  = 2'h0;
          d.grp = q.grp + 3'h1;
        end else begin
          d.ph = q.ph + 2'h1;
        end
      end else begin
        d.tst = TUNE_IDLE;
        d.grp = 3'h0;
        d.ph  = 2'h0;
      end
    end
    // Receive reset drops the tuning and the decoder history
    if (receive_reset_cmd_in) begin
      d.tst       = TUNE_IDLE;
      d.grp       = 3'h0;
      d.ph        = 2'h0;
      d.cv        = 16'h0000;
      d.have_mark = 1'b0;
      d.run       = 2'h0;
      d.b8_pend   = 2'h0;
      d.skip      = 1'b0;
      d.ovf       = 1'b0;
    end
    // Receive clock: recovered bit clock or synthesizer divider
    if (rx_clock_source_sel_in == `LCV_RS_RECOVERED) begin
      d.rdiv = 8'h00;
      if (half_tick) begin
        d.rclk = ~q.rclk;
      end
    end else if (q.rdiv >= 8'(rx_clock_source_sel_in) * `LCV_SYNTH_UNIT - 8'h01) begin
      d.rdiv = 8'h00;
      d.rclk = ~q.rclk;
    end else begin
      d.rdiv = q.rdiv + 8'h01;
    end
    // Each output pin picks any of the four channel clocks
    for (int i = 0; i < `LCV_CHANNELS; i++) begin
      psel = clock_pin_source_sel_in[i*3 +: 3];
      if (psel == 3'(Channel)) begin
        d.pins[i] = d.rclk;
      end else if (psel < 3'(`LCV_CHANNELS)) begin
        d.pins[i] = q.ck_l[psel[1:0]];
      end else begin
        d.pins[i] = 1'b0;
      end
    end
  end

  // Mode bit holds its legacy value out of reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q      <= '0;
      q.mode <= `LCV_MODE_RST;
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // Framer side buffer
  lcv_fifo #(
    .Width ($bits(rx_word_s)),
    .Depth (FifoDepth)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (bit_tick),
    .in_data_in    (word),
    .in_ready_out  (fifo_ready),
    .out_valid_out (rx_valid_out),
    .out_data_out  ({rx_first_output_out, rx_second_output_out}),
    .out_ready_in  (rx_ready_in)
  );

  assign rx_overflow_out = q.ovf;
  assign tx_line_pos_out = q.tx_p;
  assign tx_line_neg_out = q.tx_n;
  assign rx_clock_out    = q.rclk;
  assign clock_pins_out  = q.pins;
  assign cv_count_out    = q.cv;
  assign tuned_out       = q.tst[1];  // Only the done code has its upper bit set

  // =====================================================================
  // Checks
  a_conv_hides_bpv: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && conv && !cmi_err && !receive_reset_cmd_in) |=> $stable(q.cv))
    else $error("converted mark was counted");
  a_spaced_bpv_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && bipolar_violation && q.run == 2'h0 && code == CODE_AMI && q.cv != `LCV_CV_MAX
     && !receive_reset_cmd_in) |=> q.cv == $past(q.cv) + 16'h0001)
    else $error("spaced violation not counted");
  a_tuned_pair_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && tuned_on && bipolar_violation && q.run == 2'h1 && code == CODE_AMI
     && q.cv != `LCV_CV_MAX && !receive_reset_cmd_in) |=> q.cv == $past(q.cv) + 16'h0001)
    else $error("tuned paired violation not counted");
  a_long_run_missed: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && miss && !cmi_err && !receive_reset_cmd_in) |=> $stable(q.cv))
    else $error("long run violation unexpectedly counted");
  a_tune_cleared: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    receive_reset_cmd_in |=> !tuned_out ##1 (q.tst != TUNE_DONE))
    else $error("tuning survived receive reset");
  a_optical_sample: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (use_opt && half_tick && !q.half) |=> q.cmi_h1 == $past(q.o_l))
    else $error("optical half bit not sampled");
  a_dual_bypass: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && dual_rail_sel_in && line_code_field_in == CODE_AMI) |=>
    (tx_line_pos_out == $past(tx_positive_input_in)
     && tx_line_neg_out == $past(tx_negative_input_in)))
    else $error("dual rail transmit not bypassed");
  a_single_viol_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && !dual && code == CODE_HDB) |=> q.vdly[0] == $past(err))
    else $error("violation indication lost in single rail");
  a_double_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bit_tick && code == CODE_HDB && !t1_mode_in && !extended_violation_sel_in
     && !vio && !cmi_err) |-> !err)
    else $error("zero run flagged without extended detection");
  a_cv_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (q.cv != $past(q.cv)) |-> (q.cv == $past(q.cv) + 16'h0001 || q.cv == 16'h0000))
    else $error("violation counter jumped");
  a_recovered_clk: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rx_clock_source_sel_in == `LCV_RS_RECOVERED && half_tick) |=>
    rx_clock_out != $past(rx_clock_out))
    else $error("recovered clock did not toggle");
  a_pin_select: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clock_pin_source_sel_in[2:0] == 3'(Channel)) |=> clock_pins_out[0] == q.rclk)
    else $error("clock pin not following own channel");
endmodule
`default_nettype wire

// [dv/framer_model.sv]
// Framer side model: accepts receive words and counts marks per output
`timescale 1ns/1ps
`default_nettype none
module framer_model (
  input  wire logic   clk_in,
  input  wire logic   reset_n_in,
  input  wire logic   stall_in,
  input  wire logic   valid_in,
  input  wire logic   first_in,
  input  wire logic   second_in,
  output logic        ready_out,
  output logic [15:0] first_cnt_out,
  output logic [15:0] second_cnt_out
);
  // =====================================================================
  // Ready drops on command so the FIFO can be filled up
  assign ready_out = !stall_in;

  // Word taken only at an edge with valid and ready both high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      first_cnt_out  <= 16'h0000;
      second_cnt_out <= 16'h0000;
    end else if (valid_in && ready_out) begin
      first_cnt_out  <= first_cnt_out + {15'h0000, first_in};
      second_cnt_out <= second_cnt_out + {15'h0000, second_in};
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the line code and violation receiver channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top
  import lcv_pkg::*;
;
  typedef struct {
    string       pat;
    logic        mode;
    logic        dual;
    logic        tune;
    logic [15:0] dcv;
    logic [15:0] dfi;
    logic [15:0] dse;
  } row_s;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, ta = 1'b0, tb = 1'b0, mode = 1'b1;
  logic        dual = 1'b0, rrst = 1'b0, txp = 1'b0, txn = 1'b0, stall = 1'b0, ext = 1'b0;
  logic [1:0]  code = 2'b10;
  logic [2:0]  rsel = 3'h0;
  logic [11:0] psel = 12'h000;
  logic [3:0]  oclk = 4'h5, pins;
  tune_wr_s    wr = '0;
  logic        ready, valid, first, second, ovf, tpos, tneg, rclk, tuned;
  logic [15:0] cv, fcnt, scnt, f0, s0, exp_cv;
  int          failures = 0, checks_done = 0, n;
  logic [8:0]  seq [19] = '{9'h02c, 9'h1ff, 9'h0ac, 9'h02b, 9'h100, 9'h0ab, 9'h02a, 9'h1ff,
                            9'h0aa, 9'h029, 9'h1ff, 9'h0a9, 9'h028, 9'h100, 9'h0a8, 9'h027,
                            9'h1ff, 9'h0a7, 9'h000};
  // Ordinary cases: pattern, mode, dual rail, tune first, expected deltas
  row_s        rows [6] = '{
    '{"N0P0P0N0N000P000", 1'b1, 1'b0, 1'b0, 16'h0002, 16'h0000, 16'h0002},
    '{"NPP00000N0P00000", 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000},
    '{"NPP00000N0P00000", 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000},
    '{"N0PP00N0P0000000", 1'b0, 1'b0, 1'b1, 16'h0001, 16'h0000, 16'h0001},
    '{"N0N0P0P000000000", 1'b0, 1'b0, 1'b0, 16'h0002, 16'h0000, 16'h0002},
    '{"N0P0N0P000000000", 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0002, 16'h0002}};

  line_code_violation_rx line_code_violation_rx_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ternary_input_a_in(ta),
    .ternary_input_b_in(tb), .optical_rx_input_in(1'b0), .other_rx_clocks_in(oclk),
    .violation_mode_bit_in(mode), .optical_input_sel_in(1'b0), .line_code_field_in(code),
    .dual_rail_sel_in(dual), .extended_violation_sel_in(ext), .t1_mode_in(1'b0),
    .cmi_hdb3_post_in(1'b0), .global_reg_wr_in(wr), .receive_reset_cmd_in(rrst),
    .rx_clock_source_sel_in(rsel), .clock_pin_source_sel_in(psel),
    .tx_positive_input_in(txp), .tx_negative_input_in(txn), .rx_ready_in(ready),
    .rx_valid_out(valid), .rx_first_output_out(first), .rx_second_output_out(second),
    .rx_overflow_out(ovf), .tx_line_pos_out(tpos), .tx_line_neg_out(tneg),
    .rx_clock_out(rclk), .clock_pins_out(pins), .cv_count_out(cv), .tuned_out(tuned));

  framer_model framer_model_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .stall_in(stall), .valid_in(valid),
    .first_in(first), .second_in(second), .ready_out(ready), .first_cnt_out(fcnt),
    .second_cnt_out(scnt));

  // =====================================================================
  // Clock, 40 ns period
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  // Each line symbol is held for one whole bit of 12 cycles
  task automatic send(input string pat);
    for (int i = 0; i < pat.len(); i++) begin
      ta = (pat[i] == "P");
      tb = (pat[i] == "N");
      repeat (12) @(negedge clk_in);
    end
  endtask

  // Back-to-back host writes; a bad value at step five breaks the match
  task automatic tune(input logic bad, input logic exp);
    for (int i = 0; i < 19; i++) begin
      wr = '{wr_ptr: !seq[i][8], wr_data: seq[i][8],
             value: (bad && i == 4) ? 8'h11 : seq[i][7:0]};
      @(negedge clk_in);
    end
    wr = '0;
    @(negedge clk_in);
    `CHK("tuned", exp, tuned)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // =====================================================================
  // Main sequence: reset, table of line patterns, then awkward cases
  initial begin
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    exp_cv = 16'h0000;
    `CHK("cv_reset", 16'h0000, cv)
    `CHK("tuned_reset", 1'b0, tuned)
    foreach (rows[r]) begin
      mode = rows[r].mode;
      dual = rows[r].dual;
      if (rows[r].tune) tune(1'b0, 1'b1);
      f0 = fcnt;
      s0 = scnt;
      send({rows[r].pat, "0000000000"}); // Padding covers the eight bit latency
      exp_cv += rows[r].dcv;
      `CHK("cv_count", exp_cv, cv)
      `CHK("second_cnt", rows[r].dse, scnt - s0)
      if (rows[r].dual) `CHK("first_cnt", rows[r].dfi, fcnt - f0)
    end
    // Framer stalls until the FIFO refuses, then drains it
    stall = 1'b1;
    send("000000000000000000000000");
    `CHK("overflow", 1'b1, ovf)
    stall = 1'b0;
    n = 0;
    while (valid !== 1'b0 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    `CHK("drained", 1'b0, valid)
    if (n == 100) tally_and_finish();
    // Receive reset drops tuning, count and overflow; tuning must be redone
    rrst = 1'b1;
    @(negedge clk_in);
    rrst = 1'b0;
    @(negedge clk_in);
    `CHK("cv_cleared", 16'h0000, cv)
    `CHK("tuned_cleared", 1'b0, tuned)
    `CHK("ovf_cleared", 1'b0, ovf)
    tune(1'b1, 1'b0);
    tune(1'b0, 1'b1);
    // Dual rail transmit passes rails straight through
    for (int i = 0; i < 2; i++) begin
      txp = i[0];
      txn = !i[0];
      repeat (14) @(negedge clk_in);
      `CHK("tx_pos", i[0], tpos)
      `CHK("tx_neg", !i[0], tneg)
    end
    // Extended detection flags the fourth zero of a run only while selected
    dual = 1'b0;
    code = 2'b11;
    ext  = 1'b1;
    send("P000000000");
    `CHK("ext_zero_run", 16'h0001, cv)
    ext = 1'b0;
    send("N000000000");
    `CHK("double_only", 16'h0001, cv)
    // Clock pin cross connect, fields 4..7 give zero; own channel runs free
    psel = {3'h4, 3'h2, 3'h1, 3'h0};
    repeat (6) @(negedge clk_in);
    `CHK("pins_a", {3'h2, rclk}, pins)
    psel = {3'h2, 3'h3, 3'h0, 3'h1};
    repeat (6) @(negedge clk_in);
    `CHK("pins_b", {2'b10, rclk, 1'b0}, pins)
    // Synthesizer half period of twelve cycles, unlike the recovered six
    rsel = 3'h2;
    n = 0;
    repeat (6) @(negedge clk_in);
    for (int i = 0; i < 24; i++) begin
      f0[0] = rclk;
      @(negedge clk_in);
      if (rclk !== f0[0]) n++;
    end
    `CHK("synth_toggles", 32'd2, n)
    tally_and_finish();
  end
endmodule
`default_nettype wire
